// file: bench/tb_phase_and_flight_time_readout.sv
// Self-checking testbench for the phase and flight-time readout registers
`timescale 1ns/1ns
`default_nettype none
module tb_phase_and_flight_time_readout;
  import pftr_pkg::*;
  logic       clk, nrst, reg_wr, reg_rd, reg_rvalid, flight_start, flight_stop;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_phase, ref_phase, rd_q, w, lo, mid;
  logic       clk_out_shaping_sel, if_position_invert, phase_meas_enable, flight_time_enable;
  logic [2:0] clk_out_rate_sel;
  int         num_errors, total_checks, cnt;
  logic [7:0] ro_addr [5] = '{8'h3b, 8'h7d, 8'h7e, 8'h7f, 8'h55};

  pftr_readout u_dut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_phase(rx_phase),
    .ref_phase(ref_phase), .flight_start(flight_start), .flight_stop(flight_stop),
    .clk_out_rate_sel(clk_out_rate_sel), .clk_out_shaping_sel(clk_out_shaping_sel),
    .if_position_invert(if_position_invert), .phase_meas_enable(phase_meas_enable),
    .flight_time_enable(flight_time_enable));

  // Free-running 125 MHz clock
  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Strobes rise and fall at the falling edge, so each is taken at exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      num_errors++;
      $display("CHECK FAILED at %0t: read answer missing", $time);
      summarize();
    end
    d = reg_rdata;
  endtask : rd

  // Control byte as seen on the output ports; reserved bit always 0
  function automatic logic [7:0] ctrl_ports();
    return {flight_time_enable, 1'b0, phase_meas_enable, if_position_invert, clk_out_shaping_sel, clk_out_rate_sel};
  endfunction : ctrl_ports

  // Reference ticks expected over a span of system cycles
  function automatic int ticks_exp(input int cycles);
    return cycles * PFTR_REF_NUM / PFTR_REF_DEN;
  endfunction : ticks_exp

  function automatic logic [7:0] phase_exp(input logic [7:0] rx, input logic [7:0] rf, input logic inv);
    return inv ? rf - rx : rx - rf;
  endfunction : phase_exp

  initial begin
    {reg_wr, reg_rd, flight_start, flight_stop, nrst} = 5'h00;
    {reg_addr, reg_wdata, rx_phase, ref_phase} = 32'h0;
    void'($urandom(32'he98d5085));
    repeat (12) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    // Reset values of control and results, unmapped reads zero
    check(ctrl_ports(), 8'h09);
    rd(PFTR_ADDR_CTRL, rd_q);
    check(rd_q, 8'h09);
    foreach (ro_addr[i]) begin
      rd(ro_addr[i], rd_q);
      check(rd_q, 8'h00);
    end
    $display("test reset values done");
    // Control write and readback, corners first; reserved bit must stay 0
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 8'hff : (i == 1) ? 8'h40 : 8'($urandom);
      wr(PFTR_ADDR_CTRL, w);
      rd(PFTR_ADDR_CTRL, rd_q);
      check(rd_q, w & 8'hbf);
      check(ctrl_ports(), w & 8'hbf);
    end
    // Flight mode on, so writes to the flight bytes would show if they landed
    wr(PFTR_ADDR_CTRL, 8'h80);
    // Writes to result registers have no effect
    foreach (ro_addr[i]) begin
      wr(ro_addr[i], 8'($urandom) | 8'h01);
      rd(ro_addr[i], rd_q);
      check(rd_q, 8'h00);
    end
    $display("test control access done");
    // Phase refresh: nothing before the period ends, difference after
    // Samples never equal, so a missed refresh cannot hide behind a zero difference
    rx_phase = 8'($urandom);
    ref_phase = rx_phase ^ (8'($urandom) | 8'h01);
    wr(PFTR_ADDR_CTRL, 8'h20);
    repeat (985) @(negedge clk);
    rd(PFTR_ADDR_PHASE, rd_q);
    check(rd_q, 8'h00);
    repeat (20) @(negedge clk);
    rd(PFTR_ADDR_PHASE, rd_q);
    check(rd_q, phase_exp(rx_phase, ref_phase, 1'b0));
    wr(PFTR_ADDR_CTRL, 8'h30);
    // Even sample below 0x7f keeps the inverted and normal differences apart
    rx_phase = 8'($urandom) & 8'h7e;
    ref_phase = 8'hff;
    repeat (1010) @(negedge clk);
    rd(PFTR_ADDR_PHASE, rd_q);
    check(rd_q, phase_exp(rx_phase, ref_phase, 1'b1));
    w = rd_q;
    // Disabled unit holds its last result
    wr(PFTR_ADDR_CTRL, 8'h10);
    rx_phase = rx_phase + 8'h11;
    repeat (1010) @(negedge clk);
    rd(PFTR_ADDR_PHASE, rd_q);
    check(rd_q, w);
    $display("test phase unit done");
    // Flight count over 2500 cycles: 320 reference ticks, small sync slack allowed
    wr(PFTR_ADDR_CTRL, 8'h80);
    @(negedge clk);
    flight_start = 1'b1;
    repeat (2500) @(negedge clk);
    flight_stop = 1'b1;
    repeat (10) @(negedge clk);
    rd(PFTR_ADDR_FLT_LOW, lo);
    rd(PFTR_ADDR_FLT_MID, mid);
    rd(PFTR_ADDR_FLT_HIGH, rd_q);
    check(rd_q, 8'h00);
    cnt = int'({mid, lo}) - ticks_exp(2500);
    check({7'h00, cnt >= -3 && cnt <= 3}, 8'h01);
    // Middle flight byte hidden once flight mode is off
    wr(PFTR_ADDR_CTRL, 8'h00);
    rd(PFTR_ADDR_FLT_MID, rd_q);
    check(rd_q, 8'h00);
    {flight_start, flight_stop} = 2'b00;
    $display("test flight count done");
    // Reset in mid-run restores control and clears results
    wr(PFTR_ADDR_CTRL, 8'hb6);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    rd(PFTR_ADDR_CTRL, rd_q);
    check(rd_q, 8'h09);
    rd(PFTR_ADDR_PHASE, rd_q);
    check(rd_q, 8'h00);
    check(ctrl_ports(), 8'h09);
    // Flight result held a count before reset; it must read zero with the mode back on
    wr(PFTR_ADDR_CTRL, 8'h80);
    rd(PFTR_ADDR_FLT_MID, rd_q);
    check(rd_q, 8'h00);
    $display("test second reset done");
    summarize();
  end
endmodule : tb_phase_and_flight_time_readout
`default_nettype wire

// file: common/pftr_pkg.sv
// Package: register map, field layout, reset values and timing for the phase and flight-time readout
package pftr_pkg;
  // Register addresses on the register port
  localparam logic [7:0] PFTR_ADDR_CTRL      = 8'h03;
  localparam logic [7:0] PFTR_ADDR_PHASE     = 8'h3b;
  localparam logic [7:0] PFTR_ADDR_FLT_LOW   = 8'h7d;
  localparam logic [7:0] PFTR_ADDR_FLT_MID   = 8'h7e;
  localparam logic [7:0] PFTR_ADDR_FLT_HIGH  = 8'h7f;
  // Control register field positions
  localparam int PFTR_BIT_FLT_EN    = 7;
  localparam int PFTR_BIT_RSVD      = 6;
  localparam int PFTR_BIT_PHASE_EN  = 5;
  localparam int PFTR_BIT_IF_INV    = 4;
  localparam int PFTR_BIT_SHAPE     = 3;
  localparam int PFTR_RATE_MSB      = 2;
  // Reset values
  localparam logic [7:0] PFTR_CTRL_RST   = 8'h09;
  localparam logic [7:0] PFTR_RESULT_RST = 8'h00;
  // Writable mask of the control register; bit 6 stays zero
  localparam logic [7:0] PFTR_CTRL_WMASK = 8'hbf;
  // Timing at the 125 MHz system clock
  localparam int PFTR_CLK_PERIOD_PS  = 8000;
  localparam int PFTR_REF_PERIOD_PS  = 62500;
  localparam int PFTR_PHASE_UPD_NS   = 8000;
  // Reference tick: 16 MHz from 125 MHz, accumulated fractionally (16/125)
  localparam int PFTR_REF_NUM        = 16;
  localparam int PFTR_REF_DEN        = 125;
  // Phase refresh period in system cycles (longest time rounds down)
  localparam int PFTR_PHASE_UPD_CYC  = (PFTR_PHASE_UPD_NS * 1000) / PFTR_CLK_PERIOD_PS;
  // Flight counter width
  localparam int PFTR_FLT_W          = 24;
endpackage : pftr_pkg

// file: rtl/pftr_readout.sv
// Phase and flight-time result registers with the shared radio control register
// Overview of operation
// RQ1 - Flight-time bits 23..16 read at 0x7F, read-only.
// RQ2 - Flight-time counter advances once per 16 MHz reference period.
// RQ3 - Result registers are read-only, full 8-bit range, zero after reset.
// RQ4 - Control 0x03 holds rate select [2:0], shaping bit 3, reset 1001.
// RQ5 - Phase unit measures received phase against internal low-IF reference.
// RQ6 - Phase result at 0x3B, refreshed every 8 us.
// RQ7 - Control bit 5 enables phase measurement; resets to 0.
// RQ8 - Control bit 4 selects normal or inverse IF position; resets to 0.
// RQ9 - Flight-time bits 7..0 at 0x7D, 15..8 at 0x7E, when enabled.
// RQ10 - Control bit 6 reserved: reads 0, writes ignored.
`timescale 1ns/1ns
`default_nettype none
module pftr_readout (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Register port (byte access from the serial front end)
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_rvalid,
  // Receiver low-IF phase samples
  input  wire logic [7:0]           rx_phase,
  input  wire logic [7:0]           ref_phase,
  // Flight-time start and stop pins, asynchronous
  input  wire logic                 flight_start,
  input  wire logic                 flight_stop,
  // Control fields to the clock output and receiver
  output logic      [2:0]           clk_out_rate_sel,
  output logic                      clk_out_shaping_sel,
  output logic                      if_position_invert,
  output logic                      phase_meas_enable,
  output logic                      flight_time_enable
);
  import pftr_pkg::*;

  logic [7:0]            ctrl_q, ctrl_d;
  logic [7:0]            phase_q, phase_d;
  logic [15:0]           upd_cnt_q, upd_cnt_d;
  logic [7:0]            frac_q, frac_d;
  logic [PFTR_FLT_W-1:0] flt_cnt_q, flt_cnt_d;
  logic [PFTR_FLT_W-1:0] flt_res_q, flt_res_d;
  logic                  running_q, running_d;
  logic                  start_s, stop_s, start_prev_q, stop_prev_q;
  logic                  ref_tick;
  logic [7:0]            rdata_q, rdata_d;
  logic                  rvalid_q, rvalid_d;

  // Start and stop pins come from outside the clock domain
  pftr_sync3 u_sync_start (
    .clk  (clk),
    .nrst (nrst),
    .d    (flight_start),
    .q    (start_s)
  );
  pftr_sync3 u_sync_stop (
    .clk  (clk),
    .nrst (nrst),
    .d    (flight_stop),
    .q    (stop_s)
  );

  // Control register: bit 6 forced low so it never stores
  always_comb begin
    ctrl_d = ctrl_q;
    if (reg_wr && reg_addr == PFTR_ADDR_CTRL) begin
      ctrl_d = reg_wdata & PFTR_CTRL_WMASK; // RQ4 RQ7 RQ8 RQ10
    end
  end

  // Phase unit: difference of received and reference phase, inverted IF flips sign
  always_comb begin
    phase_d   = phase_q;
    upd_cnt_d = upd_cnt_q;
    if (!ctrl_q[PFTR_BIT_PHASE_EN]) begin
      upd_cnt_d = 16'h0000; // RQ7
    end else if (upd_cnt_q == 16'(PFTR_PHASE_UPD_CYC - 1)) begin
      upd_cnt_d = 16'h0000;
      if (ctrl_q[PFTR_BIT_IF_INV]) begin
        phase_d = ref_phase - rx_phase; // RQ5 RQ8
      end else begin
        phase_d = rx_phase - ref_phase; // RQ5 RQ6
      end
    end else begin
      upd_cnt_d = upd_cnt_q + 16'h0001;
    end
  end

  // Fractional accumulator gives one tick per 16 MHz reference period on average
  // Ticks land on system edges, so single periods jitter by one 8 ns cycle; long counts stay exact
  always_comb begin
    if (frac_q + 8'(PFTR_REF_NUM) >= 8'(PFTR_REF_DEN)) begin
      frac_d   = frac_q + 8'(PFTR_REF_NUM) - 8'(PFTR_REF_DEN);
      ref_tick = 1'b1;
    end else begin
      frac_d   = frac_q + 8'(PFTR_REF_NUM);
      ref_tick = 1'b0;
    end
  end

  // Flight-time counter: start edge clears and runs, stop edge latches result
  always_comb begin
    flt_cnt_d = flt_cnt_q;
    flt_res_d = flt_res_q;
    running_d = running_q;
    if (!ctrl_q[PFTR_BIT_FLT_EN]) begin
      running_d = 1'b0;
    end else if (start_s && !start_prev_q) begin
      flt_cnt_d = '0;
      running_d = 1'b1;
    end else if (running_q && stop_s && !stop_prev_q) begin
      flt_res_d = flt_cnt_q; // RQ1 RQ9
      running_d = 1'b0;
    end else if (running_q && ref_tick) begin
      flt_cnt_d = flt_cnt_q + 24'h000001; // RQ2
    end
  end

  // Read mux; results are read-only, writes to them are dropped
  always_comb begin
    rdata_d  = 8'h00;
    rvalid_d = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        PFTR_ADDR_CTRL:     rdata_d = ctrl_q;
        PFTR_ADDR_PHASE:    rdata_d = phase_q; // RQ3 RQ6
        PFTR_ADDR_FLT_LOW:  rdata_d = ctrl_q[PFTR_BIT_FLT_EN] ? flt_res_q[7:0] : 8'h00; // RQ9
        PFTR_ADDR_FLT_MID:  rdata_d = ctrl_q[PFTR_BIT_FLT_EN] ? flt_res_q[15:8] : 8'h00; // RQ9
        PFTR_ADDR_FLT_HIGH: rdata_d = ctrl_q[PFTR_BIT_FLT_EN] ? flt_res_q[23:16] : 8'h00; // RQ1
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  // All state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q       <= PFTR_CTRL_RST; // RQ4
      phase_q      <= PFTR_RESULT_RST; // RQ3
      upd_cnt_q    <= 16'h0000;
      frac_q       <= 8'h00;
      flt_cnt_q    <= '0;
      flt_res_q    <= '0; // RQ3
      running_q    <= 1'b0;
      start_prev_q <= 1'b0;
      stop_prev_q  <= 1'b0;
      rdata_q      <= 8'h00;
      rvalid_q     <= 1'b0;
    end else begin
      ctrl_q       <= ctrl_d;
      phase_q      <= phase_d;
      upd_cnt_q    <= upd_cnt_d;
      frac_q       <= frac_d;
      flt_cnt_q    <= flt_cnt_d;
      flt_res_q    <= flt_res_d;
      running_q    <= running_d;
      start_prev_q <= start_s;
      stop_prev_q  <= stop_s;
      rdata_q      <= rdata_d;
      rvalid_q     <= rvalid_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata           = rdata_q;
  assign reg_rvalid          = rvalid_q;
  assign clk_out_rate_sel    = ctrl_q[PFTR_RATE_MSB:0];
  assign clk_out_shaping_sel = ctrl_q[PFTR_BIT_SHAPE];
  assign if_position_invert  = ctrl_q[PFTR_BIT_IF_INV];
  assign phase_meas_enable   = ctrl_q[PFTR_BIT_PHASE_EN];
  assign flight_time_enable  = ctrl_q[PFTR_BIT_FLT_EN];

  // Checks
  localparam int UPD_CYC = PFTR_PHASE_UPD_CYC;

  sequence s_ctrl_write;
    reg_wr && reg_addr == PFTR_ADDR_CTRL;
  endsequence

  chk_rsvd_bit_zero: assert property (@(posedge clk) disable iff (!nrst) // RQ10
    ctrl_q[PFTR_BIT_RSVD] == 1'b0) else $error("reserved control bit set");
  chk_ctrl_write_takes: assert property (@(posedge clk) disable iff (!nrst) // RQ4
    s_ctrl_write |=> ctrl_q == ($past(reg_wdata) & PFTR_CTRL_WMASK)) else $error("control write lost");
  chk_phase_en_out: assert property (@(posedge clk) disable iff (!nrst) // RQ7
    s_ctrl_write |=> phase_meas_enable == $past(reg_wdata[PFTR_BIT_PHASE_EN])) else $error("enable bit wrong");
  chk_if_inv_out: assert property (@(posedge clk) disable iff (!nrst) // RQ8
    s_ctrl_write |=> if_position_invert == $past(reg_wdata[PFTR_BIT_IF_INV])) else $error("if invert wrong");
  chk_phase_hold_off: assert property (@(posedge clk) disable iff (!nrst) // RQ6
    !ctrl_q[PFTR_BIT_PHASE_EN] |=> $stable(phase_q)) else $error("phase moved while disabled");
  chk_phase_refresh: assert property (@(posedge clk) disable iff (!nrst) // RQ6
    ctrl_q[PFTR_BIT_PHASE_EN] && upd_cnt_q == 16'h0000
    |-> ##[1:UPD_CYC] (upd_cnt_q == 16'h0000 || !ctrl_q[PFTR_BIT_PHASE_EN])) else $error("phase refresh late");
  chk_high_read: assert property (@(posedge clk) disable iff (!nrst) // RQ1
    reg_rd && reg_addr == PFTR_ADDR_FLT_HIGH && ctrl_q[PFTR_BIT_FLT_EN] && !(reg_wr && reg_addr == PFTR_ADDR_CTRL)
    |=> reg_rvalid && reg_rdata == $past(flt_res_q[23:16])) else $error("flight high byte wrong");
  chk_low_read: assert property (@(posedge clk) disable iff (!nrst) // RQ9
    reg_rd && reg_addr == PFTR_ADDR_FLT_LOW && ctrl_q[PFTR_BIT_FLT_EN]
    |=> reg_rdata == $past(flt_res_q[7:0])) else $error("flight low byte wrong");
  chk_count_rate: assert property (@(posedge clk) disable iff (!nrst) // RQ2
    running_q && !stop_s && ctrl_q[PFTR_BIT_FLT_EN] && !(start_s && !start_prev_q) && !ref_tick
    |=> $stable(flt_cnt_q)) else $error("counter moved without reference tick");

  // Refresh due: last count of the period while the unit is enabled
  sequence s_phase_due;
    ctrl_q[PFTR_BIT_PHASE_EN] && upd_cnt_q == 16'(PFTR_PHASE_UPD_CYC - 1);
  endsequence

  // Stop edge seen while a measurement runs and no new start competes with it
  sequence s_flight_stop;
    ctrl_q[PFTR_BIT_FLT_EN] && running_q && stop_s && !stop_prev_q && !(start_s && !start_prev_q);
  endsequence

  chk_phase_load: assert property (@(posedge clk) disable iff (!nrst) // RQ5
    s_phase_due |=> phase_q == ($past(ctrl_q[PFTR_BIT_IF_INV]) ? $past(ref_phase) - $past(rx_phase)
                                                                : $past(rx_phase) - $past(ref_phase)))
    else $error("phase result not loaded");
  chk_phase_ro: assert property (@(posedge clk) disable iff (!nrst) // RQ3
    !(ctrl_q[PFTR_BIT_PHASE_EN] && upd_cnt_q == 16'(PFTR_PHASE_UPD_CYC - 1)) |=> $stable(phase_q))
    else $error("phase result changed outside a refresh");
  chk_flight_ro: assert property (@(posedge clk) disable iff (!nrst) // RQ3
    !(ctrl_q[PFTR_BIT_FLT_EN] && running_q && stop_s && !stop_prev_q) |=> $stable(flt_res_q))
    else $error("flight result changed without a stop");
  chk_flight_latch: assert property (@(posedge clk) disable iff (!nrst) // RQ9
    s_flight_stop |=> flt_res_q == $past(flt_cnt_q)) else $error("flight result not latched");
  chk_count_step: assert property (@(posedge clk) disable iff (!nrst) // RQ2
    running_q && ref_tick && ctrl_q[PFTR_BIT_FLT_EN] && !(start_s && !start_prev_q) && !(stop_s && !stop_prev_q)
    |=> flt_cnt_q == $past(flt_cnt_q) + 24'h000001) else $error("counter missed a reference tick");
endmodule : pftr_readout
`default_nettype wire

// file: rtl/pftr_sync3.sv
// Three-stage input synchroniser with agreement filter on stages two and three
`timescale 1ns/1ns
`default_nettype none
module pftr_sync3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Asynchronous input and filtered level
  input  wire logic d,
  output logic      q
);
  logic [2:0] s_q;
  logic [2:0] s_d;
  logic       q_d;
  logic       out_q;

  // Shift and accept a change only once stage two and three agree
  always_comb begin
    s_d = {s_q[1:0], d};
    q_d = (s_q[2] == s_q[1]) ? s_q[2] : out_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q   <= 3'h0;
      out_q <= 1'b0;
    end else begin
      s_q   <= s_d;
      out_q <= q_d;
    end
  end

  assign q = out_q;
endmodule : pftr_sync3
`default_nettype wire
